// [logic/alu_flags_map.svh]
`ifndef ALU_FLAGS_MAP_SVH
`define ALU_FLAGS_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CMD 10'h000
`define OFS_ACC 10'h004
`define OFS_FLAGS 10'h008
`define OFS_IRQ_STAT 10'h00C
`define OFS_IRQ_MASK 10'h010
`define RPAGE_REGION 2'h1
`define SPAGE_REGION 2'h2

// ****************************************
// command word fields
// ****************************************
`define CMD_OP_LSB 0
`define CMD_DEST_BIT 4
`define CMD_BIT_LSB 8
`define CMD_RADDR_LSB 16
`define CMD_LIT_LSB 24

// ****************************************
// flags word bit positions
// ****************************************
`define FLG_C 0
`define FLG_DC 1
`define FLG_Z 2
`define FLG_PD_N 3
`define FLG_TO_N 4
`define FLG_HALTED 5

// ****************************************
// interrupt events
// ****************************************
`define IRQ_W 3
`define IRQ_DONE 0
`define IRQ_TIMEOUT 1
`define IRQ_HALT 2

// ****************************************
// reset values
// ****************************************
`define RST_FLAG_N 1'b1
`define RST_BYTE 8'h00
`define RST_IRQ 3'h0

`endif

// [logic/alu_flags_pkg.sv]
package alu_flags_pkg;

   // instruction codes taken from the command word
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_ADC_REG = 4'h1,
      OP_ADD_REG = 4'h2,
      OP_ADC_IMM = 4'h3,
      OP_ADD_IMM = 4'h4,
      OP_AND_REG = 4'h5,
      OP_BIT_CLR = 4'h6,
      OP_WDT_CLR = 4'h7,
      OP_HALT = 4'h8,
      OP_SPAGE_WR = 4'h9,
      OP_SPAGE_RD = 4'hA
   } alu_op_t;

   // whole state of the core datapath
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic [7:0] acc;
      logic c;
      logic dc;
      logic z;
      logic pd_n;
      logic to_n;
      logic halted;
      logic [63:0][7:0] rpage;
      logic [15:0][7:0] spage;
   } core_state_t;

   // whole state of the interrupt block
   typedef struct packed {
      logic [2:0] status;
      logic [2:0] mask;
      logic irq;
   } irq_state_t;

endpackage

// [logic/arith_flags_core.sv]
// Behaviour
// - power-down flag is 1 after reset or watchdog clear, 0 after halt.
// - time-out flag is 1 after reset, watchdog clear or halt; 0 on timeout.
// - register operands use a 6-bit address, 0x00 to 0x3F.
// - secondary page moves use a 4-bit address, 0x0 to 0xF.
// - register add-with-carry adds register, accumulator and carry; sets Z, DC, C.
// - destination bit 0 writes accumulator, 1 writes the addressed register.
// - register add sums accumulator and register, no carry-in; sets Z, DC, C.
// - immediate add-with-carry adds literal and carry into accumulator; sets Z, DC, C.
// - immediate add adds literal into accumulator, no carry-in; sets Z, DC, C.
// - register AND writes destination and changes only the zero flag.
// - clear-bit zeroes one bit of a register, keeps others, no flag change.
// - carry is 1 on addition carry-out, 0 when none.
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "alu_flags_map.svh"

module arith_flags_core
(
   // clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // watchdog side
   input wire logic wdt_timeout_i,
   // status outputs
   output logic power_down_flag_n_o,
   output logic time_out_flag_n_o,
   output logic halted_o,
   output logic irq_o
);

   // ****************************************
   // state and decode
   // ****************************************
   alu_flags_pkg::core_state_t q;
   alu_flags_pkg::core_state_t d;

   logic req;
   logic wr_edge;
   logic rd_req;
   logic byte0_wr;
   logic in_rpage;
   logic in_spage;
   logic [5:0] win_ridx;
   logic [3:0] win_sidx;

   // a request is answered once; the write lands on the edge that sees ack
   assign req = wb_cyc_i & wb_stb_i;
   assign rd_req = req & ~q.ack;
   assign wr_edge = req & q.ack & wb_we_i;
   assign byte0_wr = wr_edge & wb_sel_i[0];
   assign in_rpage = (wb_adr_i[9:8] == `RPAGE_REGION);
   assign in_spage = (wb_adr_i[9:8] == `SPAGE_REGION) && (wb_adr_i[7:6] == 2'h0);
   assign win_ridx = wb_adr_i[7:2];
   assign win_sidx = wb_adr_i[5:2];

   // ****************************************
   // command word fields
   // ****************************************
   alu_flags_pkg::alu_op_t cmd_op;
   logic cmd_dest;
   logic [2:0] cmd_bit;
   logic [5:0] cmd_raddr;
   logic [3:0] cmd_saddr;
   logic [7:0] cmd_lit;
   logic cmd_wr;
   logic cmd_exec;
   logic [7:0] reg_val;

   // the command needs all four lanes so a partial write cannot fire it
   assign cmd_op = alu_flags_pkg::alu_op_t'(wb_dat_i[`CMD_OP_LSB +: 4]);
   assign cmd_dest = wb_dat_i[`CMD_DEST_BIT];
   assign cmd_bit = wb_dat_i[`CMD_BIT_LSB +: 3];
   assign cmd_raddr = wb_dat_i[`CMD_RADDR_LSB +: 6];
   assign cmd_saddr = wb_dat_i[`CMD_RADDR_LSB +: 4];
   assign cmd_lit = wb_dat_i[`CMD_LIT_LSB +: 8];
   assign cmd_wr = wr_edge && (wb_adr_i == `OFS_CMD) && (wb_sel_i == 4'hF);
   assign reg_val = q.rpage[cmd_raddr];

   // a halted core only accepts the watchdog clear
   assign cmd_exec = cmd_wr & (~q.halted | (cmd_op == alu_flags_pkg::OP_WDT_CLR));

   // ****************************************
   // adder operands
   // ****************************************
   logic imm_form;
   logic carry_form;
   logic [7:0] alu_a;
   logic [7:0] alu_b;
   logic alu_cin;
   logic alu_and;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_z;

   assign imm_form = (cmd_op == alu_flags_pkg::OP_ADC_IMM) || (cmd_op == alu_flags_pkg::OP_ADD_IMM);
   assign carry_form = (cmd_op == alu_flags_pkg::OP_ADC_REG) || (cmd_op == alu_flags_pkg::OP_ADC_IMM);
   assign alu_a = imm_form ? q.acc : reg_val;
   assign alu_b = imm_form ? cmd_lit : q.acc;
   assign alu_cin = carry_form ? q.c : 1'b0;
   assign alu_and = (cmd_op == alu_flags_pkg::OP_AND_REG);

   byte_adder u_adder
   (
      .a_i(alu_a),
      .b_i(alu_b),
      .cin_i(alu_cin),
      .and_mode_i(alu_and),
      .res_o(alu_res),
      .c_o(alu_c),
      .dc_o(alu_dc),
      .z_o(alu_z)
   );

   // ****************************************
   // interrupt status and mask
   // ****************************************
   logic [2:0] irq_events;
   logic [2:0] irq_clr;
   logic irq_mask_wr;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic irq_level;
   logic halt_exec;

   assign halt_exec = cmd_exec && (cmd_op == alu_flags_pkg::OP_HALT);
   assign irq_events = {halt_exec, wdt_timeout_i, cmd_exec};
   assign irq_clr = (byte0_wr && (wb_adr_i == `OFS_IRQ_STAT)) ? wb_dat_i[2:0] : 3'h0;
   assign irq_mask_wr = byte0_wr && (wb_adr_i == `OFS_IRQ_MASK);

   sticky_irq u_irq
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .event_i(irq_events),
      .clr_i(irq_clr),
      .mask_wr_i(irq_mask_wr),
      .mask_i(wb_dat_i[2:0]),
      .status_o(irq_status),
      .mask_o(irq_mask),
      .irq_o(irq_level)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      logic [7:0] rd_val;
      logic [7:0] cleared;
      rd_val = 8'h00;
      cleared = reg_val;
      d = q;

      // bus answer: one ack per request, dropped the cycle after
      d.ack = rd_req;
      if (rd_req)
      begin
         rd_val = 8'h00;
         if (in_rpage)
         begin
            rd_val = q.rpage[win_ridx];
         end
         else if (in_spage)
         begin
            rd_val = q.spage[win_sidx];
         end
         else if (wb_adr_i == `OFS_ACC)
         begin
            rd_val = q.acc;
         end
         else if (wb_adr_i == `OFS_FLAGS)
         begin
            rd_val = {2'h0, q.halted, q.to_n, q.pd_n, q.z, q.dc, q.c};
         end
         else if (wb_adr_i == `OFS_IRQ_STAT)
         begin
            rd_val = {5'h00, irq_status};
         end
         else if (wb_adr_i == `OFS_IRQ_MASK)
         begin
            rd_val = {5'h00, irq_mask};
         end
         d.dat = {24'h000000, rd_val};
      end

      // direct register writes from software
      if (byte0_wr)
      begin
         if (in_rpage)
         begin
            d.rpage[win_ridx] = wb_dat_i[7:0];
         end
         else if (in_spage)
         begin
            d.spage[win_sidx] = wb_dat_i[7:0];
         end
         else if (wb_adr_i == `OFS_ACC)
         begin
            d.acc = wb_dat_i[7:0];
         end
         else if (wb_adr_i == `OFS_FLAGS)
         begin
            d.c = wb_dat_i[`FLG_C];
            d.dc = wb_dat_i[`FLG_DC];
            d.z = wb_dat_i[`FLG_Z];
         end
      end

      // instruction execution, one cycle each
      if (cmd_exec)
      begin
         unique case (cmd_op)
            alu_flags_pkg::OP_ADC_REG,
            alu_flags_pkg::OP_ADD_REG:
            begin
               if (cmd_dest)
               begin
                  d.rpage[cmd_raddr] = alu_res;
               end
               else
               begin
                  d.acc = alu_res;
               end
               d.z = alu_z;
               d.dc = alu_dc;
               d.c = alu_c;
            end
            alu_flags_pkg::OP_ADC_IMM,
            alu_flags_pkg::OP_ADD_IMM:
            begin
               d.acc = alu_res;
               d.z = alu_z;
               d.dc = alu_dc;
               d.c = alu_c;
            end
            alu_flags_pkg::OP_AND_REG:
            begin
               if (cmd_dest)
               begin
                  d.rpage[cmd_raddr] = alu_res;
               end
               else
               begin
                  d.acc = alu_res;
               end
               d.z = alu_z;
            end
            alu_flags_pkg::OP_BIT_CLR:
            begin
               cleared[cmd_bit] = 1'b0;
               d.rpage[cmd_raddr] = cleared;
            end
            alu_flags_pkg::OP_WDT_CLR:
            begin
               d.pd_n = 1'b1;
               d.to_n = 1'b1;
               d.halted = 1'b0;
            end
            alu_flags_pkg::OP_HALT:
            begin
               d.pd_n = 1'b0;
               d.to_n = 1'b1;
               d.halted = 1'b1;
            end
            alu_flags_pkg::OP_SPAGE_WR:
            begin
               d.spage[cmd_saddr] = q.acc;
            end
            alu_flags_pkg::OP_SPAGE_RD:
            begin
               d.acc = q.spage[cmd_saddr];
            end
            alu_flags_pkg::OP_NOP:
            begin
               d.acc = q.acc;
            end
            default:
            begin
               d.acc = q.acc; // unused codes act as no-ops
            end
         endcase
      end

      // timeout is the last word: it beats a clear in the same cycle
      if (wdt_timeout_i)
      begin
         d.to_n = 1'b0;
         d.halted = 1'b0; // a timeout wakes the core
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.acc <= `RST_BYTE;
         q.pd_n <= `RST_FLAG_N;
         q.to_n <= `RST_FLAG_N;
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign power_down_flag_n_o = q.pd_n;
   assign time_out_flag_n_o = q.to_n;
   assign halted_o = q.halted;
   assign irq_o = irq_level;

endmodule

`default_nettype wire

// [logic/byte_adder.sv]
`timescale 1ns/100ps
`default_nettype none

module byte_adder
(
   // operands
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic cin_i,
   input wire logic and_mode_i,
   // result and flags
   output logic [7:0] res_o,
   output logic c_o,
   output logic dc_o,
   output logic z_o
);

   logic [4:0] low_sum;
   logic [4:0] high_sum;

   // split at bit 3 so the nibble carry falls out directly
   always_comb
   begin
      low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
      high_sum = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, low_sum[4]};
      res_o = and_mode_i ? (a_i & b_i) : {high_sum[3:0], low_sum[3:0]};
      c_o = high_sum[4];
      dc_o = low_sum[4];
      z_o = (res_o == 8'h00);
   end

endmodule

`default_nettype wire

// [logic/sticky_irq.sv]
`timescale 1ns/100ps
`default_nettype none
`include "alu_flags_map.svh"

module sticky_irq
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // events and software access
   input wire logic [2:0] event_i,
   input wire logic [2:0] clr_i,
   input wire logic mask_wr_i,
   input wire logic [2:0] mask_i,
   // state
   output logic [2:0] status_o,
   output logic [2:0] mask_o,
   output logic irq_o
);

   alu_flags_pkg::irq_state_t q;
   alu_flags_pkg::irq_state_t d;
   logic [2:0] status_next;

   // set wins over a write-one clear in the same cycle
   genvar i;
   generate
      for (i = 0; i < `IRQ_W; i = i + 1)
      begin : g_bit
         assign status_next[i] = event_i[i] | (q.status[i] & ~clr_i[i]);
      end
   endgenerate

   // next state
   always_comb
   begin
      d = q;
      d.status = status_next;
      if (mask_wr_i)
      begin
         d.mask = mask_i;
      end
      d.irq = |(q.status & q.mask);
   end

   // registers, frozen while the enable is low
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '{status: `RST_IRQ, mask: `RST_IRQ, irq: 1'b0};
      end
      else if (ce_i)
      begin
         q <= d;
      end
   end

   assign status_o = q.status;
   assign mask_o = q.mask;
   assign irq_o = q.irq;

endmodule

`default_nettype wire

// [tb/arith_flags_core_sva.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// bus answer and status flag checks
// ****************************************
module arith_flags_core_sva
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // watched ports
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wdt_timeout_i,
   input wire logic power_down_flag_n_o,
   input wire logic time_out_flag_n_o,
   input wire logic halted_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // a request taken by the slave, and entry into halt
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   endsequence
   sequence s_halt;
      $rose(halted_o);
   endsequence

   a_ack_next: assert property (s_req |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_reset_flags: assert property ($fell(rst_i) |-> power_down_flag_n_o && time_out_flag_n_o && !halted_o)
      else $error("flags wrong after reset");
   a_timeout_flag: assert property (ce_i && wdt_timeout_i |=> !time_out_flag_n_o && !halted_o)
      else $error("timeout did not clear time-out flag");
   a_halt_flags: assert property (s_halt |-> !power_down_flag_n_o && time_out_flag_n_o)
      else $error("halt entry with wrong flags");
   a_pd_cause: assert property ($fell(power_down_flag_n_o) |-> halted_o)
      else $error("power-down flag fell without halt");
   a_to_cause: assert property ($fell(time_out_flag_n_o) |-> $past(wdt_timeout_i))
      else $error("time-out flag fell without timeout");
   a_pd_rise: assert property ($rose(power_down_flag_n_o) |-> time_out_flag_n_o && $past(wb_ack_o))
      else $error("power-down flag rose outside a clear");
endmodule

bind arith_flags_core arith_flags_core_sva arith_flags_core_sva_i
(
   .clk_i(clk_i),
   .rst_i(rst_i),
   .ce_i(ce_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .wdt_timeout_i(wdt_timeout_i),
   .power_down_flag_n_o(power_down_flag_n_o),
   .time_out_flag_n_o(time_out_flag_n_o),
   .halted_o(halted_o)
);

`default_nettype wire

// [tb/arith_flags_core_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "alu_flags_map.svh"

module arith_flags_core_tb;
   // one alu case: op, dest, reg, literal or bit, acc, reg value, flags
   typedef struct packed {logic [3:0] op; logic d; logic [5:0] ra; logic [7:0] lit;
      logic [7:0] acc; logic [7:0] r; logic [2:0] f;} case_t;
   logic clk_i, rst_i, ce_i, cyc, stb, we, wdt;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, rd;
   logic ack, pd_n, to_n, halted, irq, to_reg;
   logic [10:0] e;
   int n_mismatch = 0;
   int n_tests = 0;
   case_t c;
   case_t tbl [0:10] = '{
      '{alu_flags_pkg::OP_ADC_REG, 1'h1, 6'h05, 8'h00, 8'h12, 8'h34, 3'h1},
      '{alu_flags_pkg::OP_ADD_REG, 1'h1, 6'h05, 8'h00, 8'h12, 8'h34, 3'h1},
      '{alu_flags_pkg::OP_ADC_IMM, 1'h0, 6'h00, 8'h34, 8'h12, 8'h00, 3'h1},
      '{alu_flags_pkg::OP_ADD_IMM, 1'h0, 6'h00, 8'h34, 8'h12, 8'h00, 3'h1},
      '{alu_flags_pkg::OP_AND_REG, 1'h1, 6'h05, 8'h00, 8'h5A, 8'hAF, 3'h3},
      '{alu_flags_pkg::OP_BIT_CLR, 1'h0, 6'h05, 8'h03, 8'h00, 8'h5A, 3'h7},
      '{alu_flags_pkg::OP_ADC_REG, 1'h0, 6'h3F, 8'h00, 8'hFF, 8'h00, 3'h1},
      '{alu_flags_pkg::OP_ADD_IMM, 1'h0, 6'h00, 8'h08, 8'h08, 8'h00, 3'h0},
      '{alu_flags_pkg::OP_AND_REG, 1'h0, 6'h00, 8'h00, 8'hF0, 8'h0F, 3'h0},
      '{alu_flags_pkg::OP_BIT_CLR, 1'h0, 6'h3F, 8'h07, 8'h00, 8'hFF, 3'h0},
      '{alu_flags_pkg::OP_ADD_REG, 1'h0, 6'h2A, 8'h00, 8'h80, 8'h80, 3'h0}};

   // 100 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   arith_flags_core arith_flags_core_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wdt_timeout_i(wdt), .power_down_flag_n_o(pd_n), .time_out_flag_n_o(to_n),
      .halted_o(halted), .irq_o(irq));

   // ****************************************
   // helpers
   // ****************************************
   // returns {carry, digit carry, zero, sum}
   function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] s;
      logic [4:0] l;
      s = a + b + ci;
      l = a[3:0] + b[3:0] + ci;
      return {s[8], l[4], s[7:0] == 8'h00, s[7:0]};
   endfunction

   task close_out;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask

   // one classic cycle; the wait is bounded so a dead slave ends the run
   task xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         n_mismatch++;
         $display("[ERR] %0t no ack", $time);
         close_out;
      end
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask

   task rdc(input logic [9:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // timeout sampled at one edge; irq follows one edge later
   task pulse_wdt;
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      {cyc, stb, we, wdt} = 4'h0;
      adr = 10'h000;
      sel = 4'h0;
      wdat = 32'h0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(`OFS_FLAGS, 32'h18);
      $display("test reset done");
      for (int i = 0; i < 11; i++)
      begin
         c = tbl[i];
         xfer(1'b1, `OFS_ACC, {24'h0, c.acc});
         xfer(1'b1, {2'h1, c.ra, 2'h0}, {24'h0, c.r});
         xfer(1'b1, `OFS_FLAGS, {29'h0, c.f});
         case (c.op)
            alu_flags_pkg::OP_ADC_REG: e = add8(c.r, c.acc, c.f[0]);
            alu_flags_pkg::OP_ADD_REG: e = add8(c.r, c.acc, 1'b0);
            alu_flags_pkg::OP_ADC_IMM: e = add8(c.acc, c.lit, c.f[0]);
            alu_flags_pkg::OP_ADD_IMM: e = add8(c.acc, c.lit, 1'b0);
            alu_flags_pkg::OP_AND_REG: e = {c.f[0], c.f[1], (c.acc & c.r) == 8'h00, c.acc & c.r};
            default: e = {c.f[0], c.f[1], c.f[2], c.r & ~(8'h01 << c.lit[2:0])};
         endcase
         to_reg = c.d || (c.op == alu_flags_pkg::OP_BIT_CLR);
         xfer(1'b1, `OFS_CMD, {c.lit, 2'h0, c.ra, 5'h00, c.lit[2:0], 3'h0, c.d, c.op});
         rdc(`OFS_ACC, {24'h0, to_reg ? c.acc : e[7:0]});
         rdc({2'h1, c.ra, 2'h0}, {24'h0, to_reg ? e[7:0] : c.r});
         rdc(`OFS_FLAGS, {29'h3, e[8], e[9], e[10]});
      end
      $display("test alu done");
      // secondary page both ways, then unmapped and write-only places
      xfer(1'b1, `OFS_ACC, 32'hA5);
      xfer(1'b1, `OFS_CMD, {12'h0, 4'hF, 12'h0, alu_flags_pkg::OP_SPAGE_WR});
      rdc(10'h23C, 32'hA5);
      xfer(1'b1, 10'h200, 32'h3C);
      xfer(1'b1, `OFS_CMD, {12'h0, 4'h0, 12'h0, alu_flags_pkg::OP_SPAGE_RD});
      rdc(`OFS_ACC, 32'h3C);
      rdc(10'h3FC, 32'h0);
      rdc(`OFS_CMD, 32'h0);
      $display("test page done");
      // timeout, halt, ignored command, wake, masked event, clear
      xfer(1'b1, `OFS_IRQ_MASK, 32'h7);
      xfer(1'b1, `OFS_IRQ_STAT, 32'h7);
      pulse_wdt;
      chk({29'h0, pd_n, to_n, irq}, 32'h5);
      xfer(1'b1, `OFS_CMD, {28'h0, alu_flags_pkg::OP_HALT});
      chk({29'h0, pd_n, to_n, halted}, 32'h3);
      xfer(1'b1, `OFS_CMD, {8'h01, 20'h0, alu_flags_pkg::OP_ADD_IMM});
      rdc(`OFS_ACC, 32'h3C);
      pulse_wdt;
      chk({29'h0, pd_n, to_n, halted}, 32'h0);
      xfer(1'b1, `OFS_IRQ_STAT, 32'h7);
      rdc(`OFS_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, `OFS_IRQ_MASK, 32'h0);
      pulse_wdt;
      chk({31'h0, irq}, 32'h0);
      rdc(`OFS_IRQ_STAT, 32'h2);
      xfer(1'b1, `OFS_CMD, {28'h0, alu_flags_pkg::OP_WDT_CLR});
      chk({29'h0, pd_n, to_n, halted}, 32'h6);
      $display("test watchdog done");
      // enable low must swallow a timeout pulse
      ce_i <= 1'b0;
      pulse_wdt;
      ce_i <= 1'b1;
      @(posedge clk_i);
      chk({31'h0, to_n}, 32'h1);
      // halt, then a second reset must bring the flags back to one
      xfer(1'b1, `OFS_CMD, {28'h0, alu_flags_pkg::OP_HALT});
      chk({29'h0, pd_n, to_n, halted}, 32'h3);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdc(`OFS_FLAGS, 32'h18);
      rdc(`OFS_ACC, 32'h0);
      $display("test enable and reset done");
      close_out;
   end
endmodule

`default_nettype wire
